// >>> dv/msim_card_model.sv
/*
 * Card model: drives the line 3 and busy pins from its own clock.
 * Assumes the bench calls drive() to change both pin levels.
 */
`timescale 1ns/100ps
`default_nettype none

module msim_card_model
(
    input  wire logic card_clk_i,
    output var  logic line3_o,
    output var  logic busy_o
);
    logic lclk = 1'b0;
    int   card_edges = 0;

    // Own 800 ns clock, unrelated in phase to the system clock
    initial
    begin
        #13;
        forever #400 lclk = ~lclk;
    end
    always @(posedge card_clk_i) card_edges++;
    initial
    begin
        line3_o = 1'b0;
        busy_o  = 1'b0;
    end

    task automatic drive(input logic l3, input logic b);
        @(posedge lclk);
        line3_o = l3;
        busy_o  = b;
    endtask
endmodule // msim_card_model

`default_nettype wire

// >>> dv/testbench.sv
/*
 * Self-checking bench for the status and interrupt block.
 * Assumes the design's own assertions guard cycle timing.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'h3f16;
    logic        ff = 1'b0, fe = 1'b0, rxf = 1'b0, txe = 1'b0;
    logic        rsp = 1'b0, nrs = 1'b0, en_e = 1'b0, l3 = 1'b0, e11 = 1'b0;
    logic [12:0] evt = 13'h0;
    logic [31:0] exp_q[$];
    wire logic [31:0] rdata;
    wire logic   card_clk, irq, line3, busy;
    int          num_errors = 0, total_checks = 0, cyc = 0;

    always #50 clk = ~clk;

    msim_status_irq #(.HALF_DIV(2)) dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .FIFO_FULL_I(ff), .FIFO_EMPTY_I(fe), .RX_SHIFT_FULL_I(rxf),
        .TX_SHIFT_EMPTY_I(txe), .LINE3_PIN_I(line3), .CARD_BUSY_PIN_I(busy),
        .RESP_RCVD_I(rsp), .NORESP_CMD_SENT_I(nrs), .EVT_I(evt),
        .CARD_CLK_O(card_clk), .IRQ_O(irq));
    msim_card_model card_u (.card_clk_i(card_clk), .line3_o(line3),
        .busy_o(busy));

    task automatic tally_and_finish;
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask

    // Drives land 1 ns after the edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1; addr <= a; wdata <= d;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        rd <= 1'b1; addr <= a;
        exp_q.push_back(e);
        tick(1);
        rd <= 1'b0;
        tick(1);
    endtask

    // The card model counts the rising card clock edges it receives
    task automatic clk_rises(input logic [31:0] want);
        logic [31:0] n;
        n = card_u.card_edges;
        tick(8);
        check(card_u.card_edges - n, want);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction

    function automatic logic [31:0] live(input logic b);
        return {25'h0, ff, fe, l3, rxf, txe, ~en_e | rxf | txe, b};
    endfunction

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk)
        if (rd_d)
            check(rdata, exp_q.pop_front());
        else if (rst_n)
            check(rdata, 32'h0);

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        tick(10);
        rst_n <= 1'b1;
        tick(2);
        rreg(8'h04, 32'h0);
        rreg(8'h00, 32'h2);
        wreg(8'h04, 32'h17ff);
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            {ff, fe, rxf, txe} <= seed[3:0];
            en_e = seed[4];
            wreg(8'h0c, {31'h0, en_e});
            wreg(8'h00, seed);
            if (seed[5] != l3)
                e11 = 1'b1;
            l3 = seed[5];
            card_u.drive(l3, seed[6]);
            tick(6);
            rreg(8'h00, live(seed[6]));
            check(irq, 1'b0);
        end
        rreg(8'h08, {20'h0, e11, 11'h0});
        {rxf, txe} <= 2'b00;
        wreg(8'h0c, 32'h1);
        tick(3);
        clk_rises(32'h2);
        rxf <= 1'b1;
        tick(2);
        clk_rises(32'h0);
        check(card_clk, 1'b0);
        // Write then read back with no gap between the strobes
        wr <= 1'b1;
        addr <= 8'h04;
        wdata <= 32'hffffffff;
        tick(1);
        wr <= 1'b0;
        rd <= 1'b1;
        exp_q.push_back(32'h1eff);
        tick(1);
        rd <= 1'b0;
        tick(1);
        for (int b = 0; b < 13; b++)
            if (b != 2 && b != 8 && b != 11)
            begin
                evt[b] <= 1'b1;
                tick(1);
                evt <= 13'h0;
                tick(1);
                check(irq, 1'b1);
                tick(3);
                check(irq, 1'b1);
                rreg(8'h08, 32'h1 << b);
                check(irq, 1'b0);
            end
        for (int k = 0; k < 2; k++)
        begin
            {rsp, nrs} <= (k == 0) ? 2'b10 : 2'b01;
            tick(1);
            {rsp, nrs} <= 2'b00;
            tick(1);
            check(irq, 1'b1);
            rreg(8'h08, 32'h4);
        end
        wreg(8'h04, 32'h800);
        l3 = ~l3;
        card_u.drive(l3, 1'b0);
        tick(6);
        check(irq, 1'b1);
        rreg(8'h08, 32'h800);
        wreg(8'h04, 32'h0);
        evt[0] <= 1'b1;
        tick(1);
        evt <= 13'h0;
        tick(2);
        check(irq, 1'b0);
        rreg(8'h08, 32'h1);
        // Event in the same cycle as the clearing read: the set wins
        wreg(8'h04, 32'h1);
        evt[0] <= 1'b1;
        tick(1);
        rd <= 1'b1;
        addr <= 8'h08;
        exp_q.push_back(32'h1);
        tick(1);
        rd <= 1'b0;
        evt <= 13'h0;
        tick(1);
        check(irq, 1'b1);
        rreg(8'h08, 32'h1);
        check(irq, 1'b0);
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire

// >>> rtl/msim_pkg.sv
/*
 * Constants for the card status and interrupt enable block: register
 * offsets, field positions, reset values and the card clock divider.
 * Assumes a plain word-wide register port addressed in bytes.
 */
package msim_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_LIVE_STATUS  = 8'h00;
    localparam logic [7:0] OFS_INT_ENABLE   = 8'h04;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
    localparam logic [7:0] OFS_CLOCK_CTRL   = 8'h0c;

    // live_status_flags fields
    localparam int unsigned LS_FIFO_FULL  = 6;
    localparam int unsigned LS_FIFO_EMPTY = 5;
    localparam int unsigned LS_LINE3      = 4;
    localparam int unsigned LS_RX_FULL    = 3;
    localparam int unsigned LS_TX_EMPTY   = 2;
    localparam int unsigned LS_CLK_STOP   = 1;
    localparam int unsigned LS_BUSY       = 0;
    localparam int unsigned LS_WIDTH      = 7;

    // Event and enable fields share one layout
    localparam int unsigned EV_TRANSFER_DONE = 12;
    localparam int unsigned EV_LINE3_EDGE    = 11;
    localparam int unsigned EV_RX_READY      = 10;
    localparam int unsigned EV_TX_READY      = 9;
    localparam int unsigned EV_RESP_CRC      = 7;
    localparam int unsigned EV_RD_CRC        = 6;
    localparam int unsigned EV_WR_CRC        = 5;
    localparam int unsigned EV_RESP_TIMEOUT  = 4;
    localparam int unsigned EV_RD_TIMEOUT    = 3;
    localparam int unsigned EV_CMD_RESP_DONE = 2;
    localparam int unsigned EV_BUSY_RELEASE  = 1;
    localparam int unsigned EV_DATA_DONE     = 0;
    localparam int unsigned EV_WIDTH         = 13;
    localparam logic [12:0] EV_IMPL_MASK     = 13'h1eff;

    // card_clock_control fields
    localparam int unsigned CC_CLK_ENABLE = 0;

    // Reset values
    localparam logic [12:0] RST_INT_ENABLE   = 13'h0000;
    localparam logic [12:0] RST_EVENT_STATUS = 13'h0000;
    localparam logic        RST_CLK_ENABLE   = 1'b0;

    // Card clock half period in system clock cycles
    localparam int unsigned CARD_HALF_DIV = 2;
endpackage : msim_pkg

// >>> rtl/msim_status_irq.sv
/*
 * Live status flags, event status and interrupt enable mask of a memory
 * card host controller, with the card clock gate and one CPU interrupt.
 * Assumes the data path supplies FIFO and shift register state and the
 * event pulses on the system clock; card pins arrive unsynchronised.
 */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module msim_status_irq
#(
    parameter int unsigned HALF_DIV = msim_pkg::CARD_HALF_DIV
)
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output var  logic [31:0] RDATA_O,
    input  wire logic        FIFO_FULL_I,
    input  wire logic        FIFO_EMPTY_I,
    input  wire logic        RX_SHIFT_FULL_I,
    input  wire logic        TX_SHIFT_EMPTY_I,
    input  wire logic        LINE3_PIN_I,
    input  wire logic        CARD_BUSY_PIN_I,
    input  wire logic        RESP_RCVD_I,
    input  wire logic        NORESP_CMD_SENT_I,
    input  wire logic [12:0] EVT_I,
    output var  logic        CARD_CLK_O,
    output var  logic        IRQ_O
);
    localparam int unsigned EW = msim_pkg::EV_WIDTH;

    logic [2:0]    line3_sync_r;
    logic [2:0]    busy_sync_r;
    logic          line3_lvl_r;
    logic          busy_lvl_r;
    logic          line3_edge;
    logic          clk_en_r;
    logic          clk_stop;
    logic          clk_stopped_r;
    logic [15:0]   div_cnt_r;
    logic          card_clk_r;
    logic [EW-1:0] ie_r;
    logic [EW-1:0] pstat_r;
    logic [EW-1:0] pstat_nxt;
    logic [EW-1:0] pend_r;
    logic [EW-1:0] pend_nxt;
    logic [EW-1:0] set_vec;
    logic [EW-1:0] rise_vec;
    logic          rd_pstat;
    logic          irq_r;
    logic [31:0]   rdata_r;
    logic [msim_pkg::LS_WIDTH-1:0] live;

    // Pins: three stages, a change counts once stages two and three agree
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            line3_sync_r <= 3'h0;
            busy_sync_r  <= 3'h0;
        end
        else
        begin
            line3_sync_r <= {line3_sync_r[1:0], LINE3_PIN_I};
            busy_sync_r  <= {busy_sync_r[1:0], CARD_BUSY_PIN_I};
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            line3_lvl_r <= 1'b0;
            busy_lvl_r  <= 1'b0;
        end
        else
        begin
            if (line3_sync_r[1] == line3_sync_r[2])
                line3_lvl_r <= line3_sync_r[2];
            if (busy_sync_r[1] == busy_sync_r[2])
                busy_lvl_r <= busy_sync_r[2];
        end
    end

    assign line3_edge = (line3_sync_r[1] == line3_sync_r[2])
                        && (line3_sync_r[2] != line3_lvl_r);

    // Card clock gate; stopping resets the divider so restart is clean
    assign clk_stop = !clk_en_r || RX_SHIFT_FULL_I || TX_SHIFT_EMPTY_I;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            div_cnt_r     <= 16'h0000;
            card_clk_r    <= 1'b0;
            clk_stopped_r <= 1'b1;
        end
        else
        begin
            clk_stopped_r <= clk_stop;
            if (clk_stop)
            begin
                div_cnt_r  <= 16'h0000;
                card_clk_r <= 1'b0;
            end
            else if (div_cnt_r == 16'(HALF_DIV - 1))
            begin
                div_cnt_r  <= 16'h0000;
                card_clk_r <= !card_clk_r;
            end
            else
                div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // Live flags are wired straight to read data only, never to the irq
    always_comb
    begin
        live = '0;
        live[msim_pkg::LS_FIFO_FULL]  = FIFO_FULL_I;
        live[msim_pkg::LS_FIFO_EMPTY] = FIFO_EMPTY_I;
        live[msim_pkg::LS_LINE3]      = line3_lvl_r;
        live[msim_pkg::LS_RX_FULL]    = RX_SHIFT_FULL_I;
        live[msim_pkg::LS_TX_EMPTY]   = TX_SHIFT_EMPTY_I;
        live[msim_pkg::LS_CLK_STOP]   = clk_stopped_r;
        live[msim_pkg::LS_BUSY]       = busy_lvl_r;
    end

    // Control registers; live status and event status ignore writes
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ie_r     <= msim_pkg::RST_INT_ENABLE;
            clk_en_r <= msim_pkg::RST_CLK_ENABLE;
        end
        else if (WR_I)
        begin
            if (ADDR_I == msim_pkg::OFS_INT_ENABLE)
                ie_r <= WDATA_I[EW-1:0] & msim_pkg::EV_IMPL_MASK;
            if (ADDR_I == msim_pkg::OFS_CLOCK_CTRL)
                clk_en_r <= WDATA_I[msim_pkg::CC_CLK_ENABLE];
        end
    end

    // Event status: a read clears, an event in the same cycle survives
    assign rd_pstat = RD_I && (ADDR_I == msim_pkg::OFS_EVENT_STATUS);

    always_comb
    begin
        set_vec = EVT_I & msim_pkg::EV_IMPL_MASK;
        set_vec[msim_pkg::EV_CMD_RESP_DONE] =
            RESP_RCVD_I || NORESP_CMD_SENT_I;
        set_vec[msim_pkg::EV_LINE3_EDGE] = line3_edge;
        rise_vec  = set_vec & (rd_pstat ? '1 : ~pstat_r);
        pstat_nxt = (rd_pstat ? '0 : pstat_r) | set_vec;
        // Pending is caught at the rise so a later enable is no new event
        pend_nxt  = (rd_pstat ? '0 : pend_r) | (rise_vec & ie_r);
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pstat_r <= msim_pkg::RST_EVENT_STATUS;
            pend_r  <= '0;
            irq_r   <= 1'b0;
        end
        else
        begin
            pstat_r <= pstat_nxt;
            pend_r  <= pend_nxt;
            irq_r   <= |pend_nxt;
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rdata_r <= 32'h0000_0000;
        else if (RD_I)
        begin
            case (ADDR_I)
                msim_pkg::OFS_LIVE_STATUS:
                    rdata_r <= {25'h0000000, live};
                msim_pkg::OFS_INT_ENABLE:
                    rdata_r <= {19'h00000, ie_r};
                msim_pkg::OFS_EVENT_STATUS:
                    rdata_r <= {19'h00000, pstat_r};
                msim_pkg::OFS_CLOCK_CTRL:
                    rdata_r <= {31'h00000000, clk_en_r};
                default:
                    rdata_r <= 32'h0000_0000;
            endcase
        end
        else
            rdata_r <= 32'h0000_0000;
    end

    assign RDATA_O    = rdata_r;
    assign CARD_CLK_O = card_clk_r;
    assign IRQ_O      = irq_r;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    logic rd_live;
    assign rd_live = RD_I && (ADDR_I == msim_pkg::OFS_LIVE_STATUS);

    AST_NO_LIVE_IRQ: assert property (
        (rise_vec & ie_r) == '0 |=> !$rose(IRQ_O))
        else $error("irq rose without an enabled event");
    AST_FIFO_BITS: assert property (
        rd_live |=> RDATA_O[31:7] == 25'h0000000
            && RDATA_O[6] == $past(FIFO_FULL_I)
            && RDATA_O[5] == $past(FIFO_EMPTY_I))
        else $error("fifo flags or reserved bits wrong");
    AST_LINE3_LEVEL: assert property (
        (line3_sync_r[2] == line3_sync_r[1]) ##1 rd_live
            |=> RDATA_O[4] == $past(line3_sync_r[2], 2))
        else $error("line3 level not reported");
    AST_RX_FULL: assert property (
        rd_live |=> RDATA_O[3] == $past(RX_SHIFT_FULL_I))
        else $error("rx shift full bit wrong");
    AST_TX_EMPTY: assert property (
        rd_live |=> RDATA_O[2] == $past(TX_SHIFT_EMPTY_I))
        else $error("tx shift empty bit wrong");
    AST_CLK_HELD: assert property (
        clk_stop |=> !CARD_CLK_O && clk_stopped_r)
        else $error("card clock not held low when stopped");
    AST_BUSY_BIT: assert property (
        (busy_sync_r[2] == busy_sync_r[1]) ##1 rd_live
            |=> RDATA_O[0] == $past(busy_sync_r[2], 2))
        else $error("busy bit wrong");
    AST_EVENT_IRQ: assert property (
        (rise_vec & ie_r) != '0 |=> IRQ_O)
        else $error("enabled event did not raise irq");
    AST_IE_LAYOUT: assert property (
        WR_I && ADDR_I == msim_pkg::OFS_INT_ENABLE ##1
            RD_I && ADDR_I == msim_pkg::OFS_INT_ENABLE
            |=> RDATA_O == ($past(WDATA_I, 2) & 32'h0000_1eff))
        else $error("enable register readback wrong");
    AST_CMD_DONE: assert property (
        RESP_RCVD_I || NORESP_CMD_SENT_I |=> pstat_r[2])
        else $error("command done flag not set");
    AST_TIMEOUT_IRQ: assert property (
        EVT_I[4] && ie_r[4] && !pstat_r[4] |=> IRQ_O)
        else $error("response timeout irq missing");
    AST_LIVE_WRITE: assert property (
        WR_I && ADDR_I == msim_pkg::OFS_LIVE_STATUS |=> $stable(ie_r)
            && $stable(clk_en_r))
        else $error("write to live status changed state");
    AST_IRQ_HOLD: assert property (
        IRQ_O && !rd_pstat |=> IRQ_O)
        else $error("irq dropped before flags cleared");
    AST_CRC_ENABLES: assert property (
        WR_I && ADDR_I == msim_pkg::OFS_INT_ENABLE
            |=> ie_r[7:5] == $past(WDATA_I[7:5]))
        else $error("crc error enables not at bits 7 to 5");
    AST_DONE_ENABLES: assert property (
        WR_I && ADDR_I == msim_pkg::OFS_INT_ENABLE
            |=> ie_r[4:0] == $past(WDATA_I[4:0]))
        else $error("timeout and done enables misplaced");
    AST_IE_RESERVED: assert property (
        RD_I && ADDR_I == msim_pkg::OFS_INT_ENABLE
            |=> RDATA_O[31:13] == 19'h00000 && !RDATA_O[8])
        else $error("reserved enable bits not zero");
    AST_CLK_TOGGLE: assert property (
        !clk_stop && div_cnt_r == 16'(HALF_DIV - 1)
            |=> CARD_CLK_O != $past(CARD_CLK_O))
        else $error("running card clock did not toggle");
    AST_SET_WINS: assert property (
        rd_pstat && (set_vec & ie_r) != '0 |=> IRQ_O)
        else $error("event during clear did not interrupt");
    AST_CLEAR_DROPS: assert property (
        rd_pstat && (set_vec & ie_r) == '0 |=> !IRQ_O)
        else $error("irq stayed after status cleared");

    COV_EVENT_IRQ: cover property ((rise_vec & ie_r) != '0 ##1 IRQ_O);
    COV_CLEAR_SET: cover property (rd_pstat && set_vec != '0);
    COV_CLK_RUN: cover property (!clk_stop [*4] ##1 CARD_CLK_O);
    COV_LINE3_EDGE: cover property (line3_edge);
endmodule : msim_status_irq

`default_nettype wire
